// *** rtl/monitor_pin_pkg.sv ***
package monitor_pin_pkg;

    // ****************************************************************
    // Slave address
    // ****************************************************************
    localparam logic [4:0] ADDR_UPPER      = 5'h0b;  // Binary 01011
    localparam logic [1:0] ADDR_LOW_GND    = 2'h2;
    localparam logic [1:0] ADDR_LOW_OPEN   = 2'h0;
    localparam logic [1:0] ADDR_LOW_VCC    = 2'h1;

    // Three-state level seen on the address-select pin
    typedef enum logic [1:0] {
        SEL_GND  = 2'b00,
        SEL_OPEN = 2'b01,
        SEL_VCC  = 2'b10
    } sel_level_t;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS    = 10;
    localparam int CLEAR_PULSE_MS   = 20;
    localparam int RESET_PULSE_MS   = 45;
    localparam int CLEAR_PULSE_CYC  = (CLEAR_PULSE_MS * 1000000
                                       + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC  = (RESET_PULSE_MS * 1000000
                                       + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W            = 23;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic       IRQ_EN_RST   = 1'b0;
    localparam logic [4:0] VID_RST      = 5'h00;
    localparam logic [6:0] ADDR_RST     = 7'h2c;

    // Pulse generator states
    typedef enum logic [1:0] {
        PG_IDLE = 2'b00,
        PG_DRIVE = 2'b01,
        PG_HOLD = 2'b10
    } pulse_state_t;

endpackage

// *** rtl/monitor_pin_control_logic.sv ***
// Behaviour
// - Three-state select pin sets address bits 1:0
// - Test mode turns select pin into output
// - Thermal pin is alert output or input
// - Clear request pulls intrusion low 20 ms
// - Interrupt output works only when enabled
// - Reset command gives 45 ms low pulse
// - Low reset pin acts as reset input
// - Test pin high selects connectivity test
// - Capture voltage code into two status fields
// - Each voltage code pin may be interrupt
// - Reset pin low restores register defaults
// - Address is 01011 plus select-pin bits
// - Select pin sampled only at power-up
`timescale 1ns/1ps
`default_nettype none

module monitor_pin_control_logic #(
    parameter int CLEAR_CYC = monitor_pin_pkg::CLEAR_PULSE_CYC,
    parameter int RESET_CYC = monitor_pin_pkg::RESET_PULSE_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    // Address-select pin: sensed level and output driver
    input  wire logic [1:0] address_select_level,
    input  wire logic       address_select_test_out_in,
    output logic            address_select_test_out_out,
    output logic            address_select_test_out_oe,
    output logic [6:0]      slave_address,
    // Connectivity test enable / analog output pin
    input  wire logic       test_enable_analog_out,
    input  wire logic       test_chain_result,
    output logic            test_mode,
    // Thermal alert pin
    input  wire logic       thermal_alert_pin_in,
    output logic            thermal_alert_pin_out,
    output logic            thermal_alert_pin_oe,
    input  wire logic       thermal_as_input,
    input  wire logic       temp_irq_pending,
    output logic            thermal_input_active,
    // Chassis intrusion pin
    input  wire logic       intrusion_input_in,
    output logic            intrusion_input_out,
    output logic            intrusion_input_oe,
    input  wire logic       intrusion_clear_cfg,
    input  wire logic       intrusion_clear_aux,
    output logic            intrusion_detected,
    // Interrupt request pin
    input  wire logic       irq_enable_wr,
    input  wire logic       irq_enable_val,
    input  wire logic       irq_pending,
    output logic            irq_enable,
    output logic            irq_n_out,
    output logic            irq_n_oe,
    // Master reset pin
    input  wire logic       reset_pin_in,
    output logic            reset_pin_out,
    output logic            reset_pin_oe,
    input  wire logic       reset_pulse_req,
    output logic            pin_reset,
    // Voltage code pins
    input  wire logic       voltage_code_bit4,
    input  wire logic       voltage_code_bit3,
    input  wire logic       voltage_code_bit2,
    input  wire logic       voltage_code_bit1,
    input  wire logic       voltage_code_bit0,
    input  wire logic [4:0] vid_irq_mode,
    output logic            vid4_status,
    output logic [3:0]      vid_low_status,
    output logic [4:0]      vid_irq_level
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    wire  [NSYNC-1:0] raw_in = {address_select_test_out_in,
        test_enable_analog_out, thermal_alert_pin_in, intrusion_input_in,
        reset_pin_in, address_select_level, voltage_code_bit4,
        voltage_code_bit3, voltage_code_bit2, voltage_code_bit1,
        voltage_code_bit0};

    // Two stages for every pin; only stage two feeds logic
    always_ff @(posedge clk) begin
        sync1_reg <= raw_in;
        sync2_reg <= sync1_reg;
    end

    wire       s_test   = sync2_reg[10];
    wire       s_thermal_alert_pin  = sync2_reg[9];
    wire       s_intr   = sync2_reg[8];
    wire       s_rstpin = sync2_reg[7];
    wire [1:0] s_sel    = sync2_reg[6:5];
    wire [4:0] s_vid    = sync2_reg[4:0];

    // ****************************************************************
    // Internal reset
    // ****************************************************************
    // External low on the reset pin resets all but address capture, the pulse
    // generator and the reset-pin driver, and our own pulse must not count as an external low
    logic  own_drive;
    wire   ext_reset = ~s_rstpin & ~own_drive;
    wire   int_rst   = rst | ext_reset;

    // ****************************************************************
    // Address capture at power-up
    // ****************************************************************
    logic       addr_taken_reg;
    logic [6:0] addr_reg;
    logic [1:0] low_bits;
    // Map three-state level to low address bits
    always_comb begin
        case (monitor_pin_pkg::sel_level_t'(s_sel))
            monitor_pin_pkg::SEL_GND:
                low_bits = monitor_pin_pkg::ADDR_LOW_GND;
            monitor_pin_pkg::SEL_VCC:
                low_bits = monitor_pin_pkg::ADDR_LOW_VCC;
            default:
                low_bits = monitor_pin_pkg::ADDR_LOW_OPEN;
        endcase
    end

    // Only rst (power-up) rearms capture; pin resets do not
    // The published address also sits here, so a pin reset cannot disturb it
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_taken_reg <= 1'b0;
            addr_reg       <= monitor_pin_pkg::ADDR_RST;
            slave_address  <= monitor_pin_pkg::ADDR_RST;
        end else begin
            if (!addr_taken_reg) begin
                addr_taken_reg <= 1'b1;
                addr_reg <= {monitor_pin_pkg::ADDR_UPPER, low_bits};
            end
            slave_address <= addr_reg;
        end
    end

    // ****************************************************************
    // Test mode and pin steering
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (int_rst) begin
            test_mode                   <= 1'b0;
            address_select_test_out_oe  <= 1'b0;
            address_select_test_out_out <= 1'b0;
            thermal_alert_pin_oe        <= 1'b0;
            thermal_alert_pin_out       <= 1'b0;
            thermal_input_active        <= 1'b0;
        end else begin
            test_mode                   <= s_test;
            address_select_test_out_oe  <= s_test;
            address_select_test_out_out <= test_chain_result;
            // Open drain low only for a pending temperature alert
            thermal_alert_pin_oe  <= ~thermal_as_input
                                     & temp_irq_pending;
            thermal_alert_pin_out <= 1'b0;
            thermal_input_active  <= thermal_as_input & ~s_thermal_alert_pin;
        end
    end

    // ****************************************************************
    // Intrusion and voltage code
    // ****************************************************************
    localparam int CNT_W_L = monitor_pin_pkg::CNT_W;
    logic [CNT_W_L-1:0] clr_cnt_reg;
    wire clr_req = intrusion_clear_cfg | intrusion_clear_aux;
    wire clr_busy = (clr_cnt_reg != '0);

    // Counter restarts while the request stands, so pulse is at least
    // the full time after the last request cycle
    always_ff @(posedge clk) begin
        if (int_rst) begin
            clr_cnt_reg        <= '0;
            intrusion_input_oe <= 1'b0;
            intrusion_detected <= 1'b0;
        end else begin
            if (clr_req)
                clr_cnt_reg <= CNT_W_L'(CLEAR_CYC);
            else if (clr_busy)
                clr_cnt_reg <= clr_cnt_reg - 1'b1;
            intrusion_input_oe <= clr_req | clr_busy;
            // Latch output is sensed high only while not clamping
            intrusion_detected <= s_intr & ~clr_busy & ~clr_req;
        end
    end
    assign intrusion_input_out = 1'b0;

    // Code pins follow the level; interrupt-mode pins report active low
    always_ff @(posedge clk) begin
        if (int_rst) begin
            vid4_status    <= monitor_pin_pkg::VID_RST[4];
            vid_low_status <= monitor_pin_pkg::VID_RST[3:0];
            vid_irq_level  <= '0;
        end else begin
            vid4_status    <= s_vid[4] & ~vid_irq_mode[4];
            vid_low_status <= s_vid[3:0] & ~vid_irq_mode[3:0];
            vid_irq_level  <= ~s_vid & vid_irq_mode;
        end
    end

    // ****************************************************************
    // Interrupt request output
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (int_rst) begin
            irq_enable <= monitor_pin_pkg::IRQ_EN_RST;
            irq_n_oe   <= 1'b0;
        end else begin
            if (irq_enable_wr)
                irq_enable <= irq_enable_val;
            irq_n_oe <= irq_enable & irq_pending;
        end
    end
    assign irq_n_out = 1'b0;

    // ****************************************************************
    // Master reset pulse
    // ****************************************************************
    monitor_pin_pkg::pulse_state_t pg_state_reg;
    logic [CNT_W_L-1:0]            rst_cnt_reg;

    // Pulse generator uses rst only; HOLD waits for the pin to rise
    // so the released pin is not taken as an external reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pg_state_reg <= monitor_pin_pkg::PG_IDLE;
            rst_cnt_reg  <= '0;
            own_drive    <= 1'b0;
        end else begin
            case (pg_state_reg)
                monitor_pin_pkg::PG_IDLE: begin
                    if (reset_pulse_req) begin
                        pg_state_reg <= monitor_pin_pkg::PG_DRIVE;
                        rst_cnt_reg  <= CNT_W_L'(RESET_CYC);
                        own_drive    <= 1'b1;
                    end
                end
                monitor_pin_pkg::PG_DRIVE: begin
                    if (rst_cnt_reg == CNT_W_L'(1))
                        pg_state_reg <= monitor_pin_pkg::PG_HOLD;
                    rst_cnt_reg <= rst_cnt_reg - 1'b1;
                end
                monitor_pin_pkg::PG_HOLD: begin
                    if (s_rstpin) begin
                        pg_state_reg <= monitor_pin_pkg::PG_IDLE;
                        own_drive    <= 1'b0;
                    end
                end
                default: pg_state_reg <= monitor_pin_pkg::PG_IDLE;
            endcase
        end
    end

    // Pin driver and reset indication
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_pin_oe <= 1'b0;
            pin_reset    <= 1'b0;
        end else begin
            reset_pin_oe <= (pg_state_reg == monitor_pin_pkg::PG_DRIVE)
                            | (reset_pulse_req
                               & pg_state_reg == monitor_pin_pkg::PG_IDLE);
            pin_reset    <= ext_reset;
        end
    end
    assign reset_pin_out = 1'b0;

endmodule // monitor_pin_control_logic
`default_nettype wire

// *** dv/monitor_pin_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Pin control checker
// ****************************************
module monitor_pin_sva #(
    parameter int CLEAR_CYC = 20,
    parameter int RESET_CYC = 45
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [6:0] slave_address,
    input wire logic       thermal_as_input,
    input wire logic       thermal_alert_pin_oe,
    input wire logic       intrusion_clear_cfg,
    input wire logic       intrusion_clear_aux,
    input wire logic       intrusion_input_oe,
    input wire logic       irq_enable,
    input wire logic       irq_n_oe,
    input wire logic       reset_pin_oe,
    input wire logic       pin_reset,
    input wire logic [4:0] vid_irq_mode,
    input wire logic       vid4_status,
    input wire logic [3:0] vid_low_status,
    input wire logic [4:0] vid_irq_level
);
    int         clr_cnt_reg;
    int         pls_cnt_reg;
    logic [3:0] run_cnt_reg;
    // Pulse widths are too long to unroll, so count them here
    always_ff @(posedge clk) begin
        clr_cnt_reg <= (rst || !intrusion_input_oe) ? 0 : clr_cnt_reg + 1;
        pls_cnt_reg <= (rst || !reset_pin_oe) ? 0 : pls_cnt_reg + 1;
        run_cnt_reg <= rst ? 4'h0 : run_cnt_reg + 4'(run_cnt_reg != 4'hf);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_irq_reset_off: assert property ($past(rst) |-> !irq_enable)
        else $error("irq enable set after reset");
    a_irq_gate_off: assert property (!irq_enable [*2] |-> !irq_n_oe)
        else $error("irq driven while disabled");
    a_addr_upper_bits: assert property (slave_address[6:2] == 5'h0b)
        else $error("address upper bits wrong");
    a_addr_stays_put: assert property (
        run_cnt_reg == 4'hf |-> $stable(slave_address))
        else $error("address changed after power-up");
    a_thermal_input_off: assert property (
        thermal_as_input |=> !thermal_alert_pin_oe)
        else $error("thermal pin driven in input mode");
    a_clear_starts: assert property (
        intrusion_clear_cfg || intrusion_clear_aux |=> intrusion_input_oe)
        else $error("clear request not clamping");
    a_clear_width: assert property (
        $fell(intrusion_input_oe) |-> clr_cnt_reg >= CLEAR_CYC + 1)
        else $error("clear pulse too short");
    a_reset_width: assert property (
        $fell(reset_pin_oe) |-> pls_cnt_reg == RESET_CYC + 1)
        else $error("reset pulse width wrong");
    a_pin_reset_clear: assert property (pin_reset [*2] |-> !irq_enable)
        else $error("pin reset kept irq enable");
    a_vid_mode_split: assert property ($stable(vid_irq_mode) |->
        ({vid4_status, vid_low_status} & vid_irq_mode) == 5'h00
        && (vid_irq_level & ~vid_irq_mode) == 5'h00)
        else $error("voltage code mode split wrong");
endmodule  // monitor_pin_sva

bind monitor_pin_control_logic monitor_pin_sva #(
    .CLEAR_CYC(CLEAR_CYC), .RESET_CYC(RESET_CYC)) checker_inst (
    .clk, .rst, .slave_address, .thermal_as_input, .thermal_alert_pin_oe,
    .intrusion_clear_cfg, .intrusion_clear_aux, .intrusion_input_oe,
    .irq_enable, .irq_n_oe, .reset_pin_oe, .pin_reset, .vid_irq_mode,
    .vid4_status, .vid_low_status, .vid_irq_level);
`default_nettype wire

// *** dv/board_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Board side: intrusion latch and pull-ups
// ****************************************
module board_model (
    input  wire logic clk,
    input  wire logic intrusion_event,
    input  wire logic board_reset_low,
    input  wire logic thermal_low,
    input  wire logic intrusion_oe,
    input  wire logic reset_oe,
    input  wire logic thermal_oe,
    output logic      intrusion_level,
    output logic      reset_level,
    output logic      thermal_level
);
    logic latch_reg = 1'b0;
    // Latch holds an event until the device clamps the pin low
    always_ff @(posedge clk) begin
        if (intrusion_oe) begin
            latch_reg <= 1'b0;
        end else if (intrusion_event) begin
            latch_reg <= 1'b1;
        end
    end
    // Pulled-up wires: any low driver wins
    assign intrusion_level = latch_reg & !intrusion_oe;
    assign reset_level     = !(reset_oe | board_reset_low);
    assign thermal_level   = !(thermal_oe | thermal_low);
endmodule  // board_model
`default_nettype wire

// *** dv/monitor_pin_control_logic_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module monitor_pin_control_logic_bench;
    localparam int CLR = 20;  // Short pulses keep the run brief
    localparam int RPL = 45;
    // ****************************************
    // Stimulus and wiring
    // ****************************************
    logic clk = 1'b0, rst = 1'b1, tst = 1'b0, chain = 1'b0, th_mode = 1'b0;
    logic th_pend = 1'b0, th_low = 1'b0, evt = 1'b0, clr_cfg = 1'b0;
    logic clr_aux = 1'b0, en_wr = 1'b0, en_val = 1'b0, pend = 1'b0;
    logic brd_rst = 1'b0, pulse_req = 1'b0;
    logic [1:0]  sel = 2'h1;
    logic [4:0]  vid = 5'h1f, vmode = 5'h00;
    logic [31:0] r;
    logic [6:0]  addr;
    int          n, n_fail = 0, n_compared = 0;
    logic [1:0]  lo_tab [3] = '{monitor_pin_pkg::ADDR_LOW_GND,
        monitor_pin_pkg::ADDR_LOW_OPEN, monitor_pin_pkg::ADDR_LOW_VCC};
    wire logic [6:0] slave_address;
    wire logic [4:0] vid_lvl;
    wire logic [3:0] vid_low;
    wire logic sel_out, sel_oe, test_mode, th_oe, th_act, in_oe, detected;
    wire logic irq_en, irq_oe, rp_oe, pin_reset, vid4, in_lvl, rp_lvl, th_lvl;
    wire logic th_out, in_out, irq_out, rp_out;
    monitor_pin_control_logic #(.CLEAR_CYC(CLR), .RESET_CYC(RPL)) DUT (
        .clk, .rst, .address_select_level(sel),
        .address_select_test_out_in(1'b0),
        .address_select_test_out_out(sel_out),
        .address_select_test_out_oe(sel_oe), .slave_address,
        .test_enable_analog_out(tst), .test_chain_result(chain), .test_mode,
        .thermal_alert_pin_in(th_lvl), .thermal_alert_pin_out(th_out),
        .thermal_alert_pin_oe(th_oe), .thermal_as_input(th_mode),
        .temp_irq_pending(th_pend), .thermal_input_active(th_act),
        .intrusion_input_in(in_lvl), .intrusion_input_out(in_out),
        .intrusion_input_oe(in_oe), .intrusion_clear_cfg(clr_cfg),
        .intrusion_clear_aux(clr_aux), .intrusion_detected(detected),
        .irq_enable_wr(en_wr), .irq_enable_val(en_val), .irq_pending(pend),
        .irq_enable(irq_en), .irq_n_out(irq_out), .irq_n_oe(irq_oe),
        .reset_pin_in(rp_lvl), .reset_pin_out(rp_out), .reset_pin_oe(rp_oe),
        .reset_pulse_req(pulse_req), .pin_reset, .voltage_code_bit4(vid[4]),
        .voltage_code_bit3(vid[3]), .voltage_code_bit2(vid[2]),
        .voltage_code_bit1(vid[1]), .voltage_code_bit0(vid[0]),
        .vid_irq_mode(vmode), .vid4_status(vid4), .vid_low_status(vid_low),
        .vid_irq_level(vid_lvl));
    board_model board (.clk, .intrusion_event(evt),
        .board_reset_low(brd_rst), .thermal_low(th_low), .intrusion_oe(in_oe),
        .reset_oe(rp_oe), .thermal_oe(th_oe), .intrusion_level(in_lvl),
        .reset_level(rp_lvl), .thermal_level(th_lvl));
    always #5 clk = ~clk;
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Sample 1 ns after the edge so register updates have landed
    task automatic chk(input string nm, input logic [6:0] e, g);
        #1;
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wr_en(input logic v);
        @(posedge clk);
        en_wr <= 1'b1;
        en_val <= v;
        @(posedge clk);
        en_wr <= 1'b0;
    endtask
    // Drops the one-cycle request and counts the pulse, bounded
    task automatic pulse_len(input bit rp, output int c);
        c = 0;
        for (int j = 0; j < 300; j++) begin
            @(posedge clk);
            {clr_cfg, clr_aux, pulse_req} <= 3'h0;
            #1;
            if ((rp ? rp_oe : in_oe) === 1'b1) c++;
            else if (c > 0) return;
        end
        n_fail++;
        finish_test();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        r = $urandom(32'heea44f11);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            sel <= 2'(i);
            rst <= 1'b1;
            tick(8);
            rst <= 1'b0;
            tick(4);
            addr = {monitor_pin_pkg::ADDR_UPPER, lo_tab[i]};
            chk("slave_address", addr, slave_address);
            chk("irq_enable", 7'h0, 7'(irq_en));
            @(posedge clk);
            sel <= 2'(i + 1);
            tick(5);
            chk("slave_address", addr, slave_address);
        end
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            wr_en(r[0]);
            pend <= r[1];
            tick(3);
            chk("irq_enable", 7'(r[0]), 7'(irq_en));
            chk("irq_oe", 7'(r[0] & r[1]), 7'(irq_oe));
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {th_mode, th_pend, th_low} <= 3'(i);
            tick(5);
            chk("thermal_oe", 7'(!th_mode && th_pend), 7'(th_oe));
            chk("thermal_in", 7'(th_mode && th_low), 7'(th_act));
        end
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            @(posedge clk);
            vid <= r[4:0];
            vmode <= r[9:5];
            tick(5);
            chk("vid4", 7'(vid[4] & ~vmode[4]), 7'(vid4));
            chk("vid_low", 7'(vid[3:0] & ~vmode[3:0]), 7'(vid_low));
            chk("vid_level", 7'(~vid & vmode), 7'(vid_lvl));
        end
        @(posedge clk);
        tst <= 1'b1;
        chain <= r[10];
        tick(6);
        chk("test_mode", 7'h1, 7'(test_mode));
        chk("select_oe", 7'h1, 7'(sel_oe));
        chk("select_out", 7'(chain), 7'(sel_out));
        @(posedge clk);
        tst <= 1'b0;
        tick(6);
        chk("select_oe", 7'h0, 7'(sel_oe));
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            evt <= 1'b1;
            @(posedge clk);
            evt <= 1'b0;
            tick(5);
            chk("detected", 7'h1, 7'(detected));
            @(posedge clk);
            {clr_cfg, clr_aux} <= k ? 2'h1 : 2'h2;
            pulse_len(1'b0, n);
            chk("clear_width", 7'(CLR + 1), 7'(n));
            tick(5);
            chk("detected", 7'h0, 7'(detected));
        end
        wr_en(1'b1);
        @(posedge clk);
        pulse_req <= 1'b1;
        pulse_len(1'b1, n);
        chk("reset_width", 7'(RPL + 1), 7'(n));
        chk("drive_lvl", 7'h0, 7'({th_out, in_out, irq_out, rp_out}));
        chk("irq_enable", 7'h1, 7'(irq_en));
        @(posedge clk);
        brd_rst <= 1'b1;
        tick(6);
        chk("pin_reset", 7'h1, 7'(pin_reset));
        @(posedge clk);
        brd_rst <= 1'b0;
        tick(6);
        chk("irq_enable", 7'h0, 7'(irq_en));
        chk("slave_address", addr, slave_address);
        finish_test();
    end
endmodule  // monitor_pin_control_logic_bench
`default_nettype wire
